// ===== tb/host_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module host_model
    import list_seq_pkg::*;
(
    // clock
    input  wire logic               clk,
    // command side
    output logic                    cmd_valid,
    output list_seq_pkg::cmd_t      cmd,
    output logic      [VW-1:0]      cmd_data,
    output logic                    save_settings_command
);
    initial begin
        cmd_valid = 1'b0;
        cmd = CMD_NONE;
        cmd_data = 16'h0000;
        save_settings_command = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // one command per strobe, data scrambled after so stale values never match
    task automatic send(input cmd_t c, input logic [VW-1:0] d);
        @(posedge clk);
        #1;
        cmd_valid = 1'b1;
        cmd = c;
        cmd_data = d;
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        cmd_data = ~d;
    endtask
    task automatic put(input logic [VW-1:0] d);
        cmd_data = d;
    endtask
    task automatic save();
        @(posedge clk);
        #1;
        save_settings_command = 1'b1;
        @(posedge clk);
        #1;
        save_settings_command = 1'b0;
    endtask
endmodule

// ===== tb/test_output_list_sequencer.sv
`timescale 1ns/10ps
module test_output_list_sequencer;
    import list_seq_pkg::*;
    logic               clk, arst_n, cv, sv, nw, pw, tw, tmw, mw, mi, oc, ov;
    list_seq_pkg::cmd_t cmd;
    logic [VW-1:0]      cd, ng, ps, tc, cs, sp, rdd, seen, last_err, hmin, hmax;
    logic [AW-1:0]      fill, hp, qs, cap;
    logic [CW-1:0]      cnt, skp;
    logic               ss, rs, ts, le, run, off, rv, ev, rec, rl, rlf;
    logic [15:0]        ec, seq[$], rdq[$];
    logic [15:0]        ex[5] = '{16'h0011, 16'h0022, 16'h0033, 16'h0022, 16'h0033};
    int                 miscompares, check_count;
    host_model i_host(.clk(clk), .cmd_valid(cv), .cmd(cmd), .cmd_data(cd),
        .save_settings_command(sv));
    output_list_sequencer i_dut(.clk(clk), .arst_n(arst_n), .cmd_valid(cv), .cmd(cmd),
        .cmd_data(cd), .neg_ceiling_we(nw), .pos_ceiling_we(pw), .ceiling_max(16'h1000),
        .save_settings_command(sv), .saved_neg_ceiling(16'h0123),
        .saved_pos_ceiling(16'h0456), .negative_protection_ceiling(ng),
        .positive_protection_ceiling(ps), .save_strobe(ss), .trig_curr_we(tw),
        .trig_mode_we(tmw), .mode_we(mw), .mode_in(mi), .model_max_current(16'h0500),
        .triggered_current_value(tc), .regulation_select(rs),
        .triggered_regulation_select(ts), .current_setpoint(cs), .over_current_pin(oc),
        .over_voltage_pin(ov), .limit_error(le), .main_setpoint(sp), .running(run),
        .output_off_ctrl(off), .fill_pointer_query(fill), .hold_points(hp),
        .readback_start_location(qs), .repeat_count_setting(cnt),
        .first_pass_skip_count(skp), .hold_min_us(hmin), .hold_max_us(hmax), .capacity(cap),
        .rd_valid(rv), .rd_data(rdd), .rd_last(rl), .err_valid(ev), .err_code(ec));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rv === 1'b1) rdq.push_back(rdd);
        if (rv === 1'b1) rlf <= rl;
        if (ev === 1'b1) last_err <= ec;
        if (rec && sp !== seen) seq.push_back(sp);
        seen <= sp;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // 0 neg, 1 pos, 2 triggered current, 3 mode, 4 triggered mode
    task automatic side(input int w, input logic [15:0] d);
        @(posedge clk);
        #1;
        i_host.put(d);
        {tmw, mw, tw, pw, nw} = 5'(1 << w);
        wt(1);
        {tmw, mw, tw, pw, nw} = 5'h00;
    endtask
    task automatic idle();
        for (int n = 0; n < 3000 && run !== 1'b0; n++) begin
            @(posedge clk);
            #1;
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        wrap_up();
    end
    initial begin
        {arst_n, nw, pw, tw, tmw, mw, mi, oc, ov, rec, seen, last_err} = '0;
        wt(20);
        arst_n = 1'b1;
        wt(2);
        chk("neg", 16'h0123, ng);
        chk("cnt", 16'h0001, 16'(cnt));
        chk("hmin", 16'h005d, hmin);
        chk("hmax", 16'h84d0, hmax);
        chk("cap", 16'h170c, 16'(cap));
        side(0, 16'h0800);
        side(1, 16'h2000);
        chk("neg", 16'h0800, ng);
        chk("pos", 16'h1000, ps);
        i_host.save();
        chk("save", 16'h0001, 16'(ss));
        side(2, 16'h0400);
        i_host.send(CMD_TRIGGER, 16'h0000);
        chk("cur", 16'h0400, cs);
        side(2, 16'h0600);
        wt(2);
        chk("err", 16'hff22, last_err);
        chk("trig", 16'h0400, tc);
        mi = 1'b1;
        side(4, 16'h0000);
        i_host.send(CMD_TRIGGER, 16'h0000);
        chk("tmode", 16'h0001, 16'(ts));
        chk("mode", 16'h0001, 16'(rs));
        ov = 1'b1;
        wt(4);
        chk("lim", 16'h0001, 16'(le));
        mi = 1'b0;
        side(3, 16'h0000);
        chk("mode", 16'h0000, 16'(rs));
        wt(4);
        chk("lim", 16'h0000, 16'(le));
        {ov, oc} = 2'b01;
        wt(4);
        chk("lim", 16'h0001, 16'(le));
        i_host.send(CMD_CLEAR, 16'h0000);
        for (int i = 0; i < 3; i++) i_host.send(CMD_ADD_SET, ex[i]);
        i_host.send(CMD_ADD_HOLD, 16'h0002);
        chk("fill", 16'h0003, 16'(fill));
        i_host.send(CMD_COUNT, 16'h0002);
        i_host.send(CMD_SKIP, 16'h0001);
        rec = 1'b1;
        i_host.send(CMD_RUN, 16'h0000);
        i_host.send(CMD_ADD_SET, 16'h0044);
        wt(2);
        chk("busy", 16'hff23, last_err);
        idle();
        rec = 1'b0;
        chk("steps", 16'h0005, 16'(seq.size()));
        foreach (seq[i]) chk("step", ex[i], seq[i]);
        chk("last", 16'h0033, sp);
        i_host.send(CMD_QSTART, 16'h0001);
        i_host.send(CMD_READ_SET, 16'h0000);
        wt(8);
        chk("rd", 16'h0002, 16'(rdq.size()));
        foreach (rdq[i]) chk("rd", ex[i+1], rdq[i]);
        chk("rlast", 16'h0001, 16'(rlf));
        i_host.send(CMD_ADD_HOLD, 16'h0002);
        last_err = 16'h0000;
        i_host.send(CMD_RUN, 16'h0000);
        wt(2);
        chk("unbal", 16'hff23, last_err);
        i_host.send(CMD_ADD_HOLD, 16'h0002);
        chk("hold", 16'h0003, 16'(hp));
        i_host.send(CMD_COUNT, 16'h0000);
        i_host.send(CMD_RUN, 16'h0000);
        wt(2000);
        chk("run", 16'h0001, 16'(run));
        i_host.send(CMD_FIXED, 16'h0000);
        wt(2);
        chk("fix", 16'h0000, 16'(run));
        i_host.send(CMD_RUN, 16'h0000);
        wt(300);
        i_host.send(CMD_HALT, 16'h0000);
        idle();
        chk("halt", 16'h0033, sp);
        i_host.send(CMD_CLEAR, 16'h0000);
        chk("clr", 16'h0000, 16'(fill));
        chk("clr", 16'h0000, 16'(skp));
        chk("clr", 16'h0000, 16'(qs));
        chk("clr", 16'h0000, 16'(off));
        wrap_up();
    end
endmodule

// ===== verilog/hold_timer.sv
`timescale 1ns/10ps
module hold_timer
    import list_seq_pkg::*;
(
    // clock and reset
    input  wire logic          clk,
    input  wire logic          arst_n,
    // control
    input  wire logic          load,
    input  wire logic [VW-1:0] hold_us,
    // status
    output logic               done
);
    logic [6:0]    pre_q, pre_d;
    logic [VW-1:0] cnt_q, cnt_d;
    logic          tick;

    assign tick = (pre_q == UNIT_LAST);

    always_comb begin
        pre_d = tick ? 7'h00 : pre_q + 7'h01;
        cnt_d = cnt_q;
        if (load) begin
            pre_d = 7'h00;
            cnt_d = hold_us;
        end else if (tick && cnt_q != 16'h0000) begin
            cnt_d = cnt_q - 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pre_q <= 7'h00;
            cnt_q <= 16'h0000;
        end else begin
            pre_q <= pre_d;
            cnt_q <= cnt_d;
        end
    end

    assign done = (cnt_q == 16'h0000) && !load;
endmodule

// ===== verilog/list_seq_pkg.sv
package list_seq_pkg;
    // table geometry
    localparam int unsigned DEPTH       = 5900;
    localparam int unsigned AW          = 13;
    localparam int unsigned VW          = 16;
    localparam int unsigned CW          = 8;
    localparam int unsigned QUERY_BURST = 16;
    localparam logic [AW-1:0] BURST_LAST = 13'h000f;
    localparam logic [AW-1:0] DEPTH_VAL  = 13'h170c;
    localparam logic [AW-1:0] ZERO_LOC   = 13'h0000;
    localparam logic [AW-1:0] ONE_LOC    = 13'h0001;
    // hold time in microseconds per lsb of the hold-time word
    localparam int unsigned CLK_MHZ      = 100;
    localparam int unsigned HOLD_UNIT_US = 1;
    localparam int unsigned HOLD_UNIT_CYC = CLK_MHZ * HOLD_UNIT_US;
    localparam logic [6:0]  UNIT_LAST    = 7'(HOLD_UNIT_CYC - 1);
    // hold time limits, microseconds
    localparam logic [VW-1:0] HOLD_MIN_US = 16'h005d;
    localparam logic [VW-1:0] HOLD_MAX_US = 16'h84d0;
    // error codes, as signed 16-bit
    localparam logic [15:0] ERR_NONE      = 16'h0000;
    localparam logic [15:0] ERR_SETTINGS  = 16'hff23;
    localparam logic [15:0] ERR_RANGE     = 16'hff22;
    // regulation encoding
    localparam logic MODE_VOLT = 1'b0;
    localparam logic MODE_CURR = 1'b1;

    typedef enum logic [3:0] {
        CMD_NONE      = 4'h0,
        CMD_CLEAR     = 4'h1,
        CMD_ADD_SET   = 4'h2,
        CMD_ADD_HOLD  = 4'h3,
        CMD_COUNT     = 4'h4,
        CMD_SKIP      = 4'h5,
        CMD_QSTART    = 4'h6,
        CMD_READ_SET  = 4'h7,
        CMD_READ_HOLD = 4'h8,
        CMD_RUN       = 4'h9,
        CMD_FIXED     = 4'ha,
        CMD_HALT      = 4'hb,
        CMD_TRIGGER   = 4'hc,
        CMD_POINTS    = 4'hd
    } cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_FETCH = 3'h1,
        ST_WAIT  = 3'h2,
        ST_HOLD  = 3'h3,
        ST_READ  = 3'h4,
        ST_RWAIT = 3'h5
    } state_t;
endpackage

// ===== verilog/list_table_mem.sv
`timescale 1ns/10ps
module list_table_mem
    import list_seq_pkg::*;
(
    // clock
    input  wire logic          clk,
    // write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [VW-1:0] wdata,
    // read port, data registered
    input  wire logic [AW-1:0] raddr,
    output logic      [VW-1:0] rdata
);
    logic [VW-1:0] mem [DEPTH];

    // no reset on the array so it maps to block ram
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

// ===== verilog/output_list_sequencer.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - accept negative protection ceiling up to one percent above rated current.
// - accept positive protection ceiling likewise and report it back.
// - ceilings persist only after the save settings command.
// - triggered current is held and applied on trigger; readable.
// - triggered current above model maximum is refused with error -222.
// - regulation mode picks the monitored limit and flags crossing it.
// - regulation readback is 0 voltage, 1 current.
// - triggered regulation mode applied on trigger, same encoding.
// - clear zeroes the fill, hold and readback start pointers and releases the output-off flag.
// - repeat count 0..255; zero repeats until fixed operation.
// - first pass runs all steps; later passes omit first nn.
// - clear resets the skip count to zero.
// - resolution readback gives minimum, maximum hold and total points.
// - table holds 5900 entries, reported as capacity.
// - setpoints fill from location 0; point count is next location.
// - a single hold time at location 0 applies to all steps.
// - unbalanced hold and setpoint counts refuse run with -221.
// - list commands while running are refused with -221.
// - fixed operation stops the sequence at once.
// - after completion output keeps the last executed setpoint.
// - each repetition goes straight from last location to the skip-count location, or to 0 if skip is not below the point count.
// - readback start location writable, cleared by clear.
// - table readback returns up to 16 values from the start location.
// - halt stops at end of current cycle, keeping last step.
module output_list_sequencer
    import list_seq_pkg::*;
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               arst_n,
    // decoded command
    input  wire logic               cmd_valid,
    input  list_seq_pkg::cmd_t      cmd,
    input  wire logic [VW-1:0]      cmd_data,
    // protection ceilings and saving
    input  wire logic               neg_ceiling_we,
    input  wire logic               pos_ceiling_we,
    input  wire logic [VW-1:0]      ceiling_max,
    input  wire logic               save_settings_command,
    input  wire logic [VW-1:0]      saved_neg_ceiling,
    input  wire logic [VW-1:0]      saved_pos_ceiling,
    output logic      [VW-1:0]      negative_protection_ceiling,
    output logic      [VW-1:0]      positive_protection_ceiling,
    output logic                    save_strobe,
    // triggered settings and regulation
    input  wire logic               trig_curr_we,
    input  wire logic               trig_mode_we,
    input  wire logic               mode_we,
    input  wire logic               mode_in,
    input  wire logic [VW-1:0]      model_max_current,
    output logic      [VW-1:0]      triggered_current_value,
    output logic                    regulation_select,
    output logic                    triggered_regulation_select,
    output logic      [VW-1:0]      current_setpoint,
    // load monitoring, from pins
    input  wire logic               over_current_pin,
    input  wire logic               over_voltage_pin,
    output logic                    limit_error,
    // sequencer outputs
    output logic      [VW-1:0]      main_setpoint,
    output logic                    running,
    output logic                    output_off_ctrl,
    output logic      [AW-1:0]      fill_pointer_query,
    output logic      [AW-1:0]      hold_points,
    output logic      [AW-1:0]      readback_start_location,
    output logic      [CW-1:0]      repeat_count_setting,
    output logic      [CW-1:0]      first_pass_skip_count,
    output logic      [VW-1:0]      hold_min_us,
    output logic      [VW-1:0]      hold_max_us,
    output logic      [AW-1:0]      capacity,
    // readback stream
    output logic                    rd_valid,
    output logic      [VW-1:0]      rd_data,
    output logic                    rd_last,
    // error post
    output logic                    err_valid,
    output logic      [15:0]        err_code
);
    import list_seq_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [1:0] ocp_q, ovp_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ocp_q <= 2'b00;
            ovp_q <= 2'b00;
        end else begin
            ocp_q <= {ocp_q[0], over_current_pin};
            ovp_q <= {ovp_q[0], over_voltage_pin};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // settings state
    logic [VW-1:0] neg_q, neg_d, pos_q, pos_d, tcur_q, tcur_d, cur_q, cur_d;
    logic          mode_q, mode_d, tmode_q, tmode_d, lerr_q, lerr_d, init_q;
    logic          sv_q, sv_d;

    function automatic logic [VW-1:0] clip(input logic [VW-1:0] v,
                                           input logic [VW-1:0] m);
        clip = (v > m) ? m : v;
    endfunction

    logic trig_hit;
    assign trig_hit = cmd_valid && cmd == CMD_TRIGGER;

    always_comb begin
        neg_d   = neg_q;
        pos_d   = pos_q;
        tcur_d  = tcur_q;
        cur_d   = cur_q;
        mode_d  = mode_q;
        tmode_d = tmode_q;
        sv_d    = save_settings_command;
        // power-up ceilings come from saved memory; unsaved edits are lost
        // restore saved ceilings
        if (!init_q) begin
            neg_d = saved_neg_ceiling;
            pos_d = saved_pos_ceiling;
        end
        if (neg_ceiling_we) begin
            neg_d = clip(cmd_data, ceiling_max);
        end
        if (pos_ceiling_we) begin
            pos_d = clip(cmd_data, ceiling_max);
        end
        if (trig_curr_we && cmd_data <= model_max_current) begin
            tcur_d = cmd_data;
        end
        if (mode_we) begin
            mode_d = mode_in;
        end
        if (trig_mode_we) begin
            tmode_d = mode_in;
        end
        if (trig_hit) begin
            cur_d = tcur_q;
        end
        if (trig_hit) begin
            mode_d = tmode_q;
        end
        lerr_d = (mode_q == MODE_VOLT) ? ocp_q[1] : ovp_q[1];
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            neg_q   <= 16'h0000;
            pos_q   <= 16'h0000;
            tcur_q  <= 16'h0000;
            cur_q   <= 16'h0000;
            mode_q  <= MODE_VOLT;
            tmode_q <= MODE_VOLT;
            lerr_q  <= 1'b0;
            sv_q    <= 1'b0;
            init_q  <= 1'b0;
        end else begin
            neg_q   <= neg_d;
            pos_q   <= pos_d;
            tcur_q  <= tcur_d;
            cur_q   <= cur_d;
            mode_q  <= mode_d;
            tmode_q <= tmode_d;
            lerr_q  <= lerr_d;
            sv_q    <= sv_d;
            init_q  <= 1'b1;
        end
    end

    assign regulation_select           = mode_q;
    assign triggered_regulation_select = tmode_q;
    assign negative_protection_ceiling = neg_q;
    assign positive_protection_ceiling = pos_q;
    assign triggered_current_value     = tcur_q;
    assign current_setpoint            = cur_q;
    assign limit_error                 = lerr_q;
    assign save_strobe                 = sv_q;

    ////////////////////////////////////////////////////////////////////////////
    // list sequencer
    state_t        st_q, st_d;
    logic [AW-1:0] fill_q, fill_d, hfill_q, hfill_d, qs_q, qs_d, loc_q, loc_d;
    logic [AW-1:0] rcnt_q, rcnt_d;
    logic [CW-1:0] rep_q, rep_d, skip_q, skip_d, pass_q, pass_d;
    logic [VW-1:0] out_q, out_d, rdd_q, rdd_d;
    logic          off_q, off_d, halt_q, halt_d, rsel_q, rsel_d;
    logic          rv_q, rv_d, rl_q, rl_d, ev_q, ev_d;
    logic [15:0]   ec_q, ec_d;
    logic          tload, tdone;
    logic [VW-1:0] set_rd, hold_rd;
    logic          is_list, busy;
    logic [AW-1:0] raddr, hraddr;

    assign busy    = (st_q == ST_FETCH) || (st_q == ST_WAIT) || (st_q == ST_HOLD);
    assign is_list = cmd inside {CMD_CLEAR, CMD_ADD_SET, CMD_ADD_HOLD, CMD_COUNT,
                                 CMD_SKIP, CMD_QSTART, CMD_READ_SET,
                                 CMD_READ_HOLD, CMD_POINTS, CMD_RUN};
    assign raddr  = (st_q == ST_READ || st_q == ST_RWAIT) ? qs_q + rcnt_q : loc_q;
    // single hold shared
    // only the hold table folds onto location 0; setpoints keep stepping
    assign hraddr = (st_q == ST_READ || st_q == ST_RWAIT || hfill_q != ONE_LOC) ?
                    raddr : ZERO_LOC;

    always_comb begin
        st_d   = st_q;
        fill_d = fill_q;
        hfill_d = hfill_q;
        qs_d   = qs_q;
        loc_d  = loc_q;
        rcnt_d = rcnt_q;
        rep_d  = rep_q;
        skip_d = skip_q;
        pass_d = pass_q;
        out_d  = out_q;
        off_d  = off_q;
        halt_d = halt_q;
        rsel_d = rsel_q;
        rdd_d  = rdd_q;
        rv_d   = 1'b0;
        rl_d   = 1'b0;
        ev_d   = 1'b0;
        ec_d   = ec_q;
        tload  = 1'b0;
        if (trig_curr_we && cmd_data > model_max_current) begin
            ev_d = 1'b1;
            ec_d = ERR_RANGE;
        end
        if (busy && cmd_valid) begin
            if (cmd == CMD_FIXED) begin
                st_d = ST_IDLE;
            end else if (cmd == CMD_HALT) begin
                halt_d = 1'b1;
            end else if (is_list) begin
                ev_d = 1'b1;
                ec_d = ERR_SETTINGS;
            end
        end
        case (st_q)
            ST_IDLE: begin
                if (cmd_valid) begin
                    case (cmd)
                        CMD_CLEAR: begin
                            fill_d  = ZERO_LOC;
                            hfill_d = ZERO_LOC;
                            off_d   = 1'b0;
                            skip_d  = 8'h00;
                            qs_d    = ZERO_LOC;
                        end
                        CMD_ADD_SET:  if (fill_q != DEPTH_VAL) fill_d = fill_q + ONE_LOC;
                        CMD_ADD_HOLD: if (hfill_q != DEPTH_VAL) hfill_d = hfill_q + ONE_LOC;
                        CMD_COUNT:  rep_d  = cmd_data[CW-1:0];
                        CMD_SKIP:   skip_d = cmd_data[CW-1:0];
                        CMD_QSTART: qs_d   = cmd_data[AW-1:0];
                        CMD_READ_SET, CMD_READ_HOLD: begin
                            rsel_d = (cmd == CMD_READ_HOLD);
                            rcnt_d = ZERO_LOC;
                            st_d   = ST_READ;
                        end
                        CMD_RUN: begin
                            if (fill_q == ZERO_LOC ||
                                (hfill_q != ONE_LOC && hfill_q != fill_q)) begin
                                ev_d = 1'b1;
                                ec_d = ERR_SETTINGS;
                            end else begin
                                loc_d  = ZERO_LOC;
                                pass_d = 8'h00;
                                halt_d = 1'b0;
                                off_d  = 1'b1;
                                st_d   = ST_FETCH;
                            end
                        end
                        default: ;
                    endcase
                end
            end
            ST_FETCH: st_d = ST_WAIT;
            ST_WAIT: begin
                out_d = set_rd;
                tload = 1'b1;
                st_d  = ST_HOLD;
            end
            ST_HOLD: begin
                if (tdone) begin
                    if (loc_q + ONE_LOC < fill_q) begin
                        loc_d = loc_q + ONE_LOC;
                        st_d  = ST_FETCH;
                    end else if (halt_q || (rep_q != 8'h00 && pass_q + 8'h01 >= rep_q)) begin
                        st_d = ST_IDLE;
                    end else begin
                        pass_d = pass_q + 8'h01;
                        loc_d  = ({5'h00, skip_q} < fill_q) ? {5'h00, skip_q} : ZERO_LOC;
                        st_d   = ST_FETCH;
                    end
                end
            end
            ST_READ: st_d = ST_RWAIT;
            ST_RWAIT: begin
                rv_d   = 1'b1;
                rdd_d  = rsel_q ? hold_rd : set_rd;
                rl_d   = (rcnt_q == BURST_LAST) ||
                         (qs_q + rcnt_q + ONE_LOC >= (rsel_q ? hfill_q : fill_q));
                rcnt_d = rcnt_q + ONE_LOC;
                st_d   = rl_d ? ST_IDLE : ST_READ;
            end
            default: st_d = ST_IDLE;
        endcase
        // fixed operation must win over whatever step the case picked
        if (busy && cmd_valid && cmd == CMD_FIXED) begin
            st_d = ST_IDLE;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= ST_IDLE;  fill_q <= ZERO_LOC; hfill_q <= ZERO_LOC;
            qs_q <= ZERO_LOC; loc_q <= ZERO_LOC;  rcnt_q <= ZERO_LOC;
            rep_q <= 8'h01;   skip_q <= 8'h00;    pass_q <= 8'h00;
            out_q <= 16'h0000; rdd_q <= 16'h0000;
            off_q <= 1'b0; halt_q <= 1'b0; rsel_q <= 1'b0;
            rv_q <= 1'b0; rl_q <= 1'b0; ev_q <= 1'b0; ec_q <= ERR_NONE;
        end else begin
            st_q <= st_d;   fill_q <= fill_d; hfill_q <= hfill_d;
            qs_q <= qs_d;   loc_q <= loc_d;   rcnt_q <= rcnt_d;
            rep_q <= rep_d; skip_q <= skip_d; pass_q <= pass_d;
            out_q <= out_d; rdd_q <= rdd_d;
            off_q <= off_d; halt_q <= halt_d; rsel_q <= rsel_d;
            rv_q <= rv_d; rl_q <= rl_d; ev_q <= ev_d; ec_q <= ec_d;
        end
    end

    list_table_mem u_set (
        .clk   (clk),
        .we    (cmd_valid && !busy && cmd == CMD_ADD_SET && fill_q != DEPTH_VAL),
        .waddr (fill_q),
        .wdata (cmd_data),
        .raddr (raddr),
        .rdata (set_rd)
    );
    list_table_mem u_hold (
        .clk   (clk),
        .we    (cmd_valid && !busy && cmd == CMD_ADD_HOLD && hfill_q != DEPTH_VAL),
        .waddr (hfill_q),
        .wdata (cmd_data),
        .raddr (hraddr),
        .rdata (hold_rd)
    );
    hold_timer u_timer (
        .clk     (clk),
        .arst_n  (arst_n),
        .load    (tload),
        .hold_us (hold_rd),
        .done    (tdone)
    );

    assign main_setpoint           = out_q;
    assign running                 = busy;
    assign output_off_ctrl         = off_q;
    assign fill_pointer_query      = fill_q;
    assign hold_points             = hfill_q;
    assign readback_start_location = qs_q;
    assign repeat_count_setting    = rep_q;
    assign first_pass_skip_count   = skip_q;
    assign hold_min_us = HOLD_MIN_US;
    assign hold_max_us = HOLD_MAX_US;
    assign capacity    = DEPTH_VAL;
    assign rd_valid    = rv_q;
    assign rd_data     = rdd_q;
    assign rd_last     = rl_q;
    assign err_valid   = ev_q;
    assign err_code    = ec_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    busy_refuse_a: assert property (@(posedge clk) disable iff (!arst_n)
        busy && cmd_valid && cmd == CMD_ADD_SET |=> err_valid && err_code == ERR_SETTINGS)
        else $error("list command accepted while running");
    fixed_stop_a: assert property (@(posedge clk) disable iff (!arst_n)
        busy && cmd_valid && cmd == CMD_FIXED |=> !running)
        else $error("fixed operation did not stop run");
    clear_ptr_a: assert property (@(posedge clk) disable iff (!arst_n)
        !busy && st_q == ST_IDLE && cmd_valid && cmd == CMD_CLEAR |=>
        fill_pointer_query == ZERO_LOC && first_pass_skip_count == 8'h00 && !output_off_ctrl)
        else $error("clear left state behind");
    range_err_a: assert property (@(posedge clk) disable iff (!arst_n)
        trig_curr_we && cmd_data > model_max_current |=>
        err_code == ERR_RANGE && $stable(triggered_current_value))
        else $error("oversize triggered current accepted");
    trig_apply_a: assert property (@(posedge clk) disable iff (!arst_n)
        trig_hit |=> current_setpoint == $past(triggered_current_value))
        else $error("trigger did not apply held current");
    burst_len_a: assert property (@(posedge clk) disable iff (!arst_n)
        st_q == ST_RWAIT |-> rcnt_q <= BURST_LAST)
        else $error("readback burst too long");
    unbal_run_a: assert property (@(posedge clk) disable iff (!arst_n)
        st_q == ST_IDLE && cmd_valid && cmd == CMD_RUN && hfill_q != ONE_LOC &&
        hfill_q != fill_q |=> !running ##0 err_code == ERR_SETTINGS)
        else $error("unbalanced list ran");
    mode_mon_a: assert property (@(posedge clk) disable iff (!arst_n)
        regulation_select == MODE_VOLT && ocp_q[1] |=> limit_error)
        else $error("over current not flagged");
    mode_cur_a: assert property (@(posedge clk) disable iff (!arst_n)
        regulation_select == MODE_CURR && ovp_q[1] |=> limit_error)
        else $error("over voltage not flagged");
endmodule
